// ### design/ust_defines.svh
// Operation
// - Slave transfer clock passes a synchroniser and edge detector, two cycles late.
// - Sync mode makes the clock pin an input as slave, output as master.
// - Input is sampled on the clock edge opposite the output change edge.
// - Polarity clear: change on rising, sample on falling; set: the reverse.
// - All thirty formats of 5-9 bits, parity choice and 1-2 stops work.
// - Frame goes start bit, data LSB first, optional parity, then stop bits.
// - After a frame the next starts at once or the line idles high.
// - Transmitter and receiver share one set of format settings.
// - Receiver checks only the first stop bit; zero there flags frame error.
// - Parity is XOR of data bits, inverted for odd, before the stops.
// - Transmit enable hands the serial output pin to the transmitter.
// - Sync mode with transmitter on clocks bits by the transfer clock.
// - Writing the data location loads the buffer and starts transmission.
// - Buffer moves to shifter when idle or right after the last stop.
// - A loaded shifter sends one frame at baud rate or transfer clock rate.
// - Unused upper bits of short characters are discarded on write.
// - Bit rate is baud tick divided by 16, 8 or 2 by mode.
// - Buffer empty flag stays set with no pending data; data write clears it.
// - Transmit done sets after a frame with buffer empty; writing one clears it.
`ifndef UST_DEFINES_SVH
`define UST_DEFINES_SVH
`define UST_OFS_DATA    8'h00
`define UST_OFS_STATUS  8'h04
`define UST_OFS_CTRL    8'h08
`define UST_OFS_BAUD    8'h0C
`define UST_ST_DRE      0
`define UST_ST_TXC      1
`define UST_ST_RXC      2
`define UST_ST_FE       3
`define UST_ST_PERR     4
`define UST_CT_TXEN     0
`define UST_CT_RXEN     1
`define UST_CT_TX9      2
`define UST_CT_SYNC     3
`define UST_CT_CPOL     4
`define UST_CT_STOP2    5
`define UST_CT_PAR_LO   6
`define UST_CT_PAR_HI   7
`define UST_CT_CS_LO    8
`define UST_CT_CS_HI    10
`define UST_CT_MASTER   11
`define UST_CT_U2X      12
`define UST_CTRL_RST    13'h0000
`define UST_BAUD_RST    12'h000
`define UST_DIV_NORM    4'hF
`define UST_DIV_DBL     4'h7
`define UST_HALF_NORM   4'h7
`define UST_HALF_DBL    4'h3
`endif

// ### design/ust_pkg.sv
package ust_pkg;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP1, TX_STOP2} ust_tx_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} ust_rx_t;
endpackage

// ### design/ust_baud_gen.sv
`timescale 1ns/1ps
module ust_baud_gen (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic [11:0] divisor,
  input  wire logic        reload,
  output logic             tick
);
  logic [11:0] cnt_ff;
  logic [11:0] nxt_cnt;

  // Tick rate is clk / (divisor + 1)
  assign tick    = (cnt_ff == 12'h000);
  assign nxt_cnt = (reload | tick) ? divisor : cnt_ff - 12'h001;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      cnt_ff <= 12'h000;
    else
      cnt_ff <= nxt_cnt;
  end
endmodule

// ### design/ust_pin_sync.sv
`timescale 1ns/1ps
module ust_pin_sync (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic pin_in,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic meta_ff;
  logic sync_ff;
  logic last_ff;

  // Edge seen two clocks after the pin moves
  assign level = sync_ff;
  assign rise  = sync_ff & ~last_ff;
  assign fall  = ~sync_ff & last_ff;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_ff <= 1'b1;
      sync_ff <= 1'b1;
      last_ff <= 1'b1;
    end
    else
    begin
      meta_ff <= pin_in;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end
endmodule

// ### design/ust_top.sv
// The AHB-Lite interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "ust_defines.svh"
module ust_top (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        rxd_in,
  output logic             txd_out,
  output logic             txd_oe_n,
  input  wire logic        xck_in,
  output logic             xck_out,
  output logic             xck_oe_n
);
  function automatic logic [3:0] nbits(input logic [2:0] cs);
    case (cs)
      3'h0: nbits = 4'h5;
      3'h1: nbits = 4'h6;
      3'h2: nbits = 4'h7;
      3'h7: nbits = 4'h9;
      default: nbits = 4'h8;
    endcase
  endfunction
  function automatic logic [8:0] dmask(input logic [2:0] cs);
    dmask = ~(9'h1FF << nbits(cs));
  endfunction
  logic [12:0]     ctrl_ff;
  logic [11:0]     baud_ff;
  logic            wr_ff;
  logic [7:0]      ofs_ff;
  logic [31:0]     hrdata_ff;
  logic [8:0]      buf_ff;
  logic            full_ff, txc_ff, par_ff, phase_ff, xck_ff;
  logic [3:0]      pre_ff;
  ust_pkg::ust_tx_t tst_ff, nxt_tst;
  logic            txd_ff, nxt_txd;
  logic [8:0]      sh_ff, nxt_sh;
  logic [3:0]      tcnt_ff, nxt_tcnt;
  logic            load, fend;
  ust_pkg::ust_rx_t rst_ff, nxt_rst;
  logic [3:0]      ros_ff, rcnt_ff;
  logic [8:0]      rsh_ff, rbuf_ff;
  logic            rpar_ff, rxc_ff, fe_ff, perr_ff;
  logic            baud_tick, s_rise, s_fall, rx_lvl;
  // Bus decode
  wire        acc     = hsel & htrans[1] & hready;
  wire        rd_now  = acc & ~hwrite;
  wire [7:0]  a_ofs   = haddr[7:0];
  wire        wr_data = wr_ff & (ofs_ff == `UST_OFS_DATA);
  wire        wr_stat = wr_ff & (ofs_ff == `UST_OFS_STATUS);
  wire        wr_ctrl = wr_ff & (ofs_ff == `UST_OFS_CTRL);
  wire        wr_baud = wr_ff & (ofs_ff == `UST_OFS_BAUD);
  wire        rd_data = rd_now & (a_ofs == `UST_OFS_DATA);

  // Format fields shared by both directions
  wire        tx_en   = ctrl_ff[`UST_CT_TXEN];
  wire        rx_en   = ctrl_ff[`UST_CT_RXEN];
  wire        sync_m  = ctrl_ff[`UST_CT_SYNC];
  wire        cpol    = ctrl_ff[`UST_CT_CPOL];
  wire        stop2   = ctrl_ff[`UST_CT_STOP2];
  wire [1:0]  pmode   = ctrl_ff[`UST_CT_PAR_HI:`UST_CT_PAR_LO];
  wire [2:0]  csize   = ctrl_ff[`UST_CT_CS_HI:`UST_CT_CS_LO];
  wire        master  = ctrl_ff[`UST_CT_MASTER];
  wire        u2x     = ctrl_ff[`UST_CT_U2X];
  wire        par_en  = pmode[1];
  wire        odd     = pmode[0];
  wire [3:0]  nb      = nbits(csize);
  wire        dre     = ~full_ff;
  wire [31:0] stat_v  = {27'h0, perr_ff, fe_ff, rxc_ff, txc_ff, dre};
  wire [31:0] rd_val  = (a_ofs == `UST_OFS_DATA)   ? {23'h0, rbuf_ff} :
                        (a_ofs == `UST_OFS_STATUS) ? stat_v :
                        (a_ofs == `UST_OFS_CTRL)   ? {19'h0, ctrl_ff} :
                        (a_ofs == `UST_OFS_BAUD)   ? {20'h0, baud_ff} : 32'h0;

  // Ninth bit is taken from control at the moment of the data write
  wire [8:0]  wr_char = {ctrl_ff[`UST_CT_TX9], hwdata[7:0]} & dmask(csize);

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_ff;

  ust_baud_gen u_baud (
    .clk     (clk),
    .arst_n  (arst_n),
    .divisor (baud_ff),
    .reload  (wr_baud),
    .tick    (baud_tick)
  );

  ust_pin_sync u_xck_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .pin_in (xck_in),
    .level  (),
    .rise   (s_rise),
    .fall   (s_fall)
  );

  ust_pin_sync u_rxd_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .pin_in (rxd_in),
    .level  (rx_lvl),
    .rise   (),
    .fall   ()
  );

  // Clock edges; master output is phase xor polarity, so change is phase rising
  wire is_master  = sync_m & master;
  wire m_rise     = baud_tick & ~phase_ff;
  wire m_fall     = baud_tick & phase_ff;
  wire change_evt = is_master ? m_rise : (cpol ? s_fall : s_rise);
  wire sample_evt = is_master ? m_fall : (cpol ? s_rise : s_fall);
  wire [3:0] div  = u2x ? `UST_DIV_DBL : `UST_DIV_NORM;
  wire [3:0] half = u2x ? `UST_HALF_DBL : `UST_HALF_NORM;
  wire async_tick = baud_tick & (pre_ff == div);
  wire tx_tick    = sync_m ? change_evt : async_tick;
  // Disable waits for shifter and buffer to drain
  wire tx_run     = tx_en | (tst_ff != ust_pkg::TX_IDLE) | full_ff;

  assign txd_out  = txd_ff;
  assign txd_oe_n = ~tx_run;
  assign xck_out  = xck_ff;
  assign xck_oe_n = ~is_master;

  always_comb
  begin
    nxt_tst  = tst_ff;
    nxt_txd  = txd_ff;
    nxt_sh   = sh_ff;
    nxt_tcnt = tcnt_ff;
    load     = 1'b0;
    fend     = 1'b0;
    if (tx_tick)
    begin
      case (tst_ff)
        ust_pkg::TX_IDLE:  load = full_ff & tx_run;
        ust_pkg::TX_START:
        begin
          nxt_txd  = sh_ff[0];
          nxt_sh   = {1'b0, sh_ff[8:1]};
          nxt_tcnt = 4'h1;
          nxt_tst  = ust_pkg::TX_DATA;
        end
        ust_pkg::TX_DATA:
        begin
          if (tcnt_ff == nb)
          begin
            nxt_txd = par_en ? par_ff : 1'b1;
            nxt_tst = par_en ? ust_pkg::TX_PAR : ust_pkg::TX_STOP1;
          end
          else
          begin
            nxt_txd  = sh_ff[0];
            nxt_sh   = {1'b0, sh_ff[8:1]};
            nxt_tcnt = tcnt_ff + 4'h1;
          end
        end
        ust_pkg::TX_PAR:
        begin
          nxt_txd = 1'b1;
          nxt_tst = ust_pkg::TX_STOP1;
        end
        ust_pkg::TX_STOP1:
        begin
          fend    = ~stop2;
          nxt_tst = stop2 ? ust_pkg::TX_STOP2 : tst_ff;
        end
        ust_pkg::TX_STOP2: fend = 1'b1;
        default:           nxt_tst = ust_pkg::TX_IDLE;
      endcase
      if (fend)
      begin
        load    = full_ff;
        nxt_tst = ust_pkg::TX_IDLE;
        nxt_txd = 1'b1;
      end
      if (load)
      begin
        nxt_sh  = buf_ff;
        nxt_txd = 1'b0;
        nxt_tst = ust_pkg::TX_START;
      end
    end
  end

  // Receiver: async uses baud ticks as oversampling, sync uses the sample edge
  wire rx_smp_a = baud_tick & (ros_ff == ((rst_ff == ust_pkg::RX_START) ? half : div));
  wire rx_smp   = sync_m ? sample_evt : rx_smp_a;
  wire rx_start = rx_en & ~rx_lvl & (sync_m ? sample_evt : baud_tick);
  wire rx_fin   = (rst_ff == ust_pkg::RX_STOP) & rx_smp;
  wire [3:0] nxt_ros = ~baud_tick ? ros_ff :
                       (rx_smp_a | (rst_ff == ust_pkg::RX_IDLE)) ? 4'h0 : ros_ff + 4'h1;

  always_comb
  begin
    nxt_rst = rst_ff;
    case (rst_ff)
      ust_pkg::RX_IDLE:
        if (rx_start)
          nxt_rst = sync_m ? ust_pkg::RX_DATA : ust_pkg::RX_START;
      ust_pkg::RX_START:
        if (rx_smp)
          nxt_rst = rx_lvl ? ust_pkg::RX_IDLE : ust_pkg::RX_DATA;
      ust_pkg::RX_DATA:
        if (rx_smp & (rcnt_ff == nb - 4'h1))
          nxt_rst = par_en ? ust_pkg::RX_PAR : ust_pkg::RX_STOP;
      ust_pkg::RX_PAR:
        if (rx_smp)
          nxt_rst = ust_pkg::RX_STOP;
      // Second stop bit is never looked at
      ust_pkg::RX_STOP:
        if (rx_smp)
          nxt_rst = ust_pkg::RX_IDLE;
      default: nxt_rst = ust_pkg::RX_IDLE;
    endcase
  end

  wire [8:0] rx_shin = rsh_ff | ({8'h0, rx_lvl} << rcnt_ff);
  wire       rx_data = (rst_ff == ust_pkg::RX_DATA) & rx_smp;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_ff     <= 1'b0;
      ofs_ff    <= 8'h00;
      hrdata_ff <= 32'h0;
      ctrl_ff   <= `UST_CTRL_RST;
      baud_ff   <= `UST_BAUD_RST;
    end
    else
    begin
      wr_ff     <= acc & hwrite;
      ofs_ff    <= acc ? a_ofs : ofs_ff;
      hrdata_ff <= rd_now ? rd_val : 32'h0;
      ctrl_ff   <= wr_ctrl ? hwdata[12:0] : ctrl_ff;
      baud_ff   <= wr_baud ? hwdata[11:0] : baud_ff;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      buf_ff   <= 9'h000;
      full_ff  <= 1'b0;
      txc_ff   <= 1'b0;
      par_ff   <= 1'b0;
      tst_ff   <= ust_pkg::TX_IDLE;
      txd_ff   <= 1'b1;
      sh_ff    <= 9'h000;
      tcnt_ff  <= 4'h0;
      pre_ff   <= 4'h0;
      phase_ff <= 1'b0;
      xck_ff   <= 1'b0;
    end
    else
    begin
      buf_ff   <= wr_data ? wr_char : buf_ff;
      full_ff  <= wr_data | (full_ff & ~load);
      txc_ff   <= (fend & ~full_ff) | (txc_ff & ~(wr_stat & hwdata[`UST_ST_TXC]));
      par_ff   <= load ? (^buf_ff) ^ odd : par_ff;
      tst_ff   <= nxt_tst;
      txd_ff   <= nxt_txd;
      sh_ff    <= nxt_sh;
      tcnt_ff  <= nxt_tcnt;
      pre_ff   <= baud_tick ? ((pre_ff == div) ? 4'h0 : pre_ff + 4'h1) : pre_ff;
      phase_ff <= is_master & (phase_ff ^ baud_tick);
      xck_ff   <= (is_master & (phase_ff ^ baud_tick)) ^ cpol;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_ff  <= ust_pkg::RX_IDLE;
      ros_ff  <= 4'h0;
      rcnt_ff <= 4'h0;
      rsh_ff  <= 9'h000;
      rpar_ff <= 1'b0;
      rbuf_ff <= 9'h000;
      rxc_ff  <= 1'b0;
      fe_ff   <= 1'b0;
      perr_ff <= 1'b0;
    end
    else
    begin
      rst_ff  <= nxt_rst;
      ros_ff  <= nxt_ros;
      rcnt_ff <= (rst_ff == ust_pkg::RX_DATA) ? rcnt_ff + {3'h0, rx_data} : 4'h0;
      // Shifted data must survive parity and stop so the buffer can take it
      rsh_ff  <= (rst_ff == ust_pkg::RX_IDLE) ? 9'h000 : (rx_data ? rx_shin : rsh_ff);
      rpar_ff <= ((rst_ff == ust_pkg::RX_PAR) & rx_smp) ? rx_lvl : rpar_ff;
      rbuf_ff <= rx_fin ? rsh_ff : rbuf_ff;
      rxc_ff  <= rx_fin | (rxc_ff & ~rd_data);
      fe_ff   <= rx_fin ? ~rx_lvl : fe_ff;
      perr_ff <= rx_fin ? par_en & (rpar_ff ^ (^rsh_ff) ^ odd) : perr_ff;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence frame_end_s;
    fend && !full_ff;
  endsequence
  sequence load_s;
    load && tx_tick;
  endsequence
  dre_clear_a: assert property (
    wr_data |=> !dre) else $error("buffer empty flag not cleared by data write");
  txc_set_a: assert property (
    frame_end_s |=> txc_ff && txd_ff) else $error("transmit done not set after frame");
  start_low_a: assert property (
    load_s |=> (!txd_ff && tst_ff == ust_pkg::TX_START)) else $error("start bit not low");
  idle_high_a: assert property (
    (tst_ff == ust_pkg::TX_IDLE) |-> txd_ff) else $error("idle line not high");
  parity_bit_a: assert property (
    (tst_ff == ust_pkg::TX_PAR) |-> (txd_ff == par_ff)) else $error("parity bit wrong");
  frame_err_a: assert property (
    rx_fin |=> (fe_ff == !$past(rx_lvl))) else $error("frame error not from first stop");
  pin_take_a: assert property (
    tx_en |-> !txd_oe_n) else $error("serial output not taken while enabled");
  async_div_a: assert property (
    async_tick |=> (!async_tick)[*7]) else $error("async bit ticks too close");
  master_clk_a: assert property (
    (is_master && $past(is_master) && baud_tick && $stable(cpol)) |=> xck_out != $past(xck_out))
    else $error("master clock did not follow baud tick");
  clk_dir_a: assert property (
    sync_m |-> (xck_oe_n == !master)) else $error("clock pin direction wrong");
endmodule

// ### tb/ust_remote_dev.sv
`timescale 1ns/1ps
module ust_remote_dev (
  input  wire logic        clk,
  input  wire logic        txd_pin,
  input  wire logic        xck_pin,
  input  wire logic [1:0]  mode,
  input  wire logic        cpol,
  input  wire logic [3:0]  nb,
  input  wire logic        par_en,
  input  wire logic        two_stop,
  input  wire logic [15:0] bp,
  input  wire logic        slv_run,
  input  wire logic        rx_go,
  input  wire logic [7:0]  rx_word,
  input  wire logic [1:0]  rx_bad,
  output logic             rxd,
  output logic             xck_drv,
  output logic             got,
  output logic [10:0]      got_word
);
  logic [8:0] d;
  logic       b;
  logic       p;
  logic       s;
  int         i;
  int         j;

  task automatic smp(input int n, output logic v);
    if (mode == 2'h0)
      repeat (n) @(posedge clk);
    else if (cpol)
      @(posedge xck_pin);
    else
      @(negedge xck_pin);
    v = txd_pin;
  endtask

  initial
  begin
    got = 1'h0;
    got_word = 11'h0;
    forever
    begin
      do smp(1, b); while (b !== 1'h0);
      if (mode == 2'h0)
        repeat (bp / 2) @(posedge clk);
      d = 9'h0;
      for (i = 0; i < nb; i++)
      begin
        smp(bp, b);
        d[i] = b;
      end
      p = 1'h0;
      if (par_en)
        smp(bp, p);
      smp(bp, s);
      if (two_stop)
      begin
        smp(bp, b);
        s = s & b;
      end
      got_word <= {s, p, d};
      got <= 1'h1;
      @(posedge clk);
      got <= 1'h0;
    end
  end

  // Slave clock runs only while a frame is wanted and rests at its idle level
  initial
  begin
    xck_drv = 1'h0;
    forever
    begin
      @(posedge clk);
      if (slv_run)
      begin
        repeat (6) @(posedge clk);
        xck_drv <= ~xck_drv;
        repeat (6) @(posedge clk);
        xck_drv <= ~xck_drv;
      end
      else
        xck_drv <= cpol;
    end
  end

  // Sender: eight data bits, no parity, two stop bits, either stop may be spoiled
  initial
  begin
    rxd = 1'h1;
    forever
    begin
      @(posedge clk);
      if (rx_go)
      begin
        rxd <= 1'h0;
        repeat (bp) @(posedge clk);
        for (j = 0; j < 8; j++)
        begin
          rxd <= rx_word[j];
          repeat (bp) @(posedge clk);
        end
        rxd <= (rx_bad != 2'h1);
        repeat (bp) @(posedge clk);
        rxd <= (rx_bad != 2'h2);
        repeat (bp) @(posedge clk);
        rxd <= 1'h1;
      end
    end
  end
endmodule

// ### tb/testbench.sv
`timescale 1ns/1ps
`include "ust_defines.svh"
module testbench;
  logic        clk;
  logic        arst_n;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        rxd;
  logic        txd_out;
  logic        txd_oe_n;
  logic        xck_out;
  logic        xck_oe_n;
  logic        xck_drv;
  logic [1:0]  mode;
  logic        cpol;
  logic [3:0]  nb;
  logic        par_en;
  logic        par_odd;
  logic        two_stop;
  logic [15:0] bp;
  logic        slv_run;
  logic        rx_go;
  logic [7:0]  rx_word;
  logic [1:0]  rx_bad;
  logic        got;
  logic [10:0] got_word;
  logic [31:0] seed;
  logic [31:0] rd;
  logic [31:0] r;
  logic [31:0] ctrl;
  logic [10:0] exp_q[$];
  logic [2:0]  cs_t [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7, 3'h7};
  logic [1:0]  par_t [6] = '{2'h0, 2'h2, 2'h3, 2'h2, 2'h3, 2'h0};
  int          miscompares;
  int          compares;
  int          cycles;
  int          k;
  wire         txd_pin = txd_oe_n ? 1'h1 : txd_out;
  wire         xck_pin = xck_oe_n ? xck_drv : xck_out;

  ust_top ust_top_inst (.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(), .hrdata(hrdata), .rxd_in(rxd), .txd_out(txd_out),
    .txd_oe_n(txd_oe_n), .xck_in(xck_pin), .xck_out(xck_out), .xck_oe_n(xck_oe_n));

  ust_remote_dev ust_remote_dev_inst (.clk(clk), .txd_pin(txd_pin), .xck_pin(xck_pin),
    .mode(mode), .cpol(cpol), .nb(nb), .par_en(par_en), .two_stop(two_stop), .bp(bp),
    .slv_run(slv_run), .rx_go(rx_go), .rx_word(rx_word), .rx_bad(rx_bad), .rxd(rxd),
    .xck_drv(xck_drv), .got(got), .got_word(got_word));

  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(input logic [31:0] g, input logic [31:0] e, input string what);
    compares++;
    if (g !== e)
    begin
      miscompares++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, g, e);
    end
  endtask

  task automatic check_frame(input logic [10:0] g);
    logic [10:0] e;
    e = 11'hXXX;
    if (exp_q.size() > 0)
      e = exp_q.pop_front();
    compares++;
    if (g !== e)
    begin
      miscompares++;
      $display("mismatch at %0t: frame got %h expected %h", $time, g, e);
    end
  endtask

  task automatic give_verdict();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'h1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'h1);
    hsel   <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'h1);
    rd = hrdata;
  endtask

  task automatic set_fmt(input logic [2:0] cs, input logic [1:0] par, input logic st2,
                         input logic u2x, input logic syn, input logic mst, input logic pol);
    ctrl = 32'h0;
    ctrl[`UST_CT_TXEN] = 1'h1;
    ctrl[`UST_CT_RXEN] = 1'h1;
    ctrl[`UST_CT_STOP2] = st2;
    ctrl[`UST_CT_PAR_HI:`UST_CT_PAR_LO] = par;
    ctrl[`UST_CT_CS_HI:`UST_CT_CS_LO] = cs;
    ctrl[`UST_CT_U2X] = u2x;
    ctrl[`UST_CT_SYNC] = syn;
    ctrl[`UST_CT_MASTER] = mst;
    ctrl[`UST_CT_CPOL] = pol;
    bus(1'h1, `UST_OFS_CTRL, ctrl);
    nb <= (cs == 3'h7) ? 4'h9 : {1'h0, cs} + 4'h5;
    par_en <= par[1];
    par_odd <= par[0];
    two_stop <= st2;
    cpol <= pol;
    mode <= syn ? (mst ? 2'h1 : 2'h2) : 2'h0;
    // Divisor 3 gives a baud tick every 4 clocks
    bp <= u2x ? 16'h20 : 16'h40;
  endtask

  task automatic send_char(input logic [31:0] d);
    logic [8:0] m;
    do bus(1'h0, `UST_OFS_STATUS, 32'h0); while (rd[`UST_ST_DRE] !== 1'h1);
    bus(1'h1, `UST_OFS_STATUS, 32'h2);
    if (nb == 4'h9)
    begin
      ctrl[`UST_CT_TX9] = d[8];
      bus(1'h1, `UST_OFS_CTRL, ctrl);
    end
    bus(1'h1, `UST_OFS_DATA, d);
    m = d[8:0] & ((9'h1 << nb) - 9'h1);
    exp_q.push_back({1'h1, par_en & (^m ^ par_odd), m});
  endtask

  task automatic wait_done();
    do bus(1'h0, `UST_OFS_STATUS, 32'h0); while (rd[`UST_ST_TXC] !== 1'h1);
    check(rd[`UST_ST_DRE], 1'h1, "empty flag");
    check(exp_q.size(), 0, "frames outstanding");
    check(txd_pin, 1'h1, "idle line");
    bus(1'h1, `UST_OFS_STATUS, 32'h2);
    bus(1'h0, `UST_OFS_STATUS, 32'h0);
    check(rd[`UST_ST_TXC], 1'h0, "done flag clear");
  endtask

  always @(posedge clk)
    if (got === 1'h1)
      check_frame(got_word);

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      miscompares++;
      give_verdict();
    end
  end

  initial
  begin
    {arst_n, hsel, hwrite, slv_run, rx_go, cpol, par_en, par_odd, two_stop} = 9'h0;
    {haddr, hwdata, ctrl, rd} = 128'h0;
    {htrans, mode, rx_bad, rx_word} = 14'h0;
    nb = 4'h8;
    bp = 16'h40;
    seed = 32'hC33031E9;
    miscompares = 0;
    compares = 0;
    cycles = 0;
    repeat (12) @(posedge clk);
    arst_n <= 1'h1;
    @(posedge clk);
    check(txd_pin, 1'h1, "idle line");
    bus(1'h0, `UST_OFS_STATUS, 32'h0);
    check(rd, 32'h1, "status reset");
    bus(1'h0, `UST_OFS_CTRL, 32'h0);
    check(rd, 32'h0, "control reset");
    bus(1'h1, 8'h10, 32'hFFFFFFFF);
    bus(1'h0, 8'h10, 32'h0);
    check(rd, 32'h0, "unmapped read");
    bus(1'h1, `UST_OFS_BAUD, 32'h3);
    bus(1'h0, `UST_OFS_BAUD, 32'h0);
    check(rd, 32'h3, "divisor");
    $display("test registers finished");
    for (k = 0; k < 6; k++)
    begin
      set_fmt(cs_t[k], par_t[k], k[0], k[1], 1'h0, 1'h0, 1'h0);
      send_char(rnd());
      wait_done();
      check(txd_oe_n, 1'h0, "pin owned");
    end
    $display("test formats finished");
    set_fmt(3'h7, 2'h2, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0);
    send_char(rnd());
    send_char(rnd());
    wait_done();
    $display("test back to back finished");
    set_fmt(3'h3, 2'h0, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0);
    // The spoiled second stop looks like a new start, so that case runs last
    for (k = 0; k < 3; k++)
    begin
      r = rnd();
      rx_word <= r[7:0];
      rx_bad <= k[1:0];
      rx_go <= 1'h1;
      @(posedge clk);
      rx_go <= 1'h0;
      do bus(1'h0, `UST_OFS_STATUS, 32'h0); while (rd[`UST_ST_RXC] !== 1'h1);
      check(rd[`UST_ST_FE], k == 1, "frame error flag");
      bus(1'h0, `UST_OFS_DATA, 32'h0);
      check(rd, {24'h0, r[7:0]}, "received char");
      // The sender is still in its stop bits and would miss the next request
      repeat (2 * bp) @(posedge clk);
    end
    $display("test receive finished");
    for (k = 0; k < 4; k++)
    begin
      set_fmt(3'h3, 2'h3, 1'h0, 1'h0, 1'h1, k < 2, k[0]);
      slv_run <= (k >= 2);
      send_char(rnd());
      wait_done();
      check(xck_oe_n, k >= 2, "clock pin direction");
      slv_run <= 1'h0;
    end
    $display("test synchronous finished");
    give_verdict();
  end
endmodule
